// [rtl/spb_pkg.sv]
// Purpose: Shared constants and types for the synchronous peripheral bus cycle.
// Assumes: One core clock tick equals one half of a processor system clock.
// Notes: Bus states S0..S7 each last one core clock tick, except S5, which holds until the divider reaches PHASE_PRE_S6.
package spb_pkg;
	// ---------------------------------------------------------------
	// Bus widths
	// ---------------------------------------------------------------
	localparam int ADDR_W = 23;   // Word address bits.
	localparam int DATA_W = 16;   // Data bus width.
	// ---------------------------------------------------------------
	// Enable clock timing, in system clocks and core ticks
	// ---------------------------------------------------------------
	localparam int TICKS_PER_SYS = 2;   // Core ticks per system clock.
	localparam int EN_DIVIDE = 10;      // Enable period in system clocks.
	localparam int EN_LOW_SYS = 6;      // Enable low time in system clocks.
	localparam int EN_PHASES = EN_DIVIDE * TICKS_PER_SYS;
	localparam int EN_RISE_PHASE = EN_LOW_SYS * TICKS_PER_SYS;
	localparam int REC_BEST_SYS = 3;    // Best recognition, clocks before rise.
	localparam int REC_WORST_SYS = 2;   // Worst recognition, clocks before rise.
	localparam int REC_FIRST = EN_RISE_PHASE - REC_BEST_SYS * TICKS_PER_SYS;
	localparam int REC_LAST = EN_RISE_PHASE - REC_WORST_SYS * TICKS_PER_SYS;
	localparam logic [4:0] PHASE_LAST = 5'(EN_PHASES - 1);
	localparam logic [4:0] PHASE_PRE_S6 = 5'(EN_PHASES - 2);
	localparam logic [4:0] PHASE_RISE_M1 = 5'(EN_RISE_PHASE - 1);
	localparam logic [4:0] PHASE_REC_FIRST = 5'(REC_FIRST);
	localparam logic [4:0] PHASE_REC_LAST = 5'(REC_LAST);
	localparam logic [4:0] PHASE_RESET = 5'h00;
	// ---------------------------------------------------------------
	// Function codes and autovector
	// ---------------------------------------------------------------
	localparam logic [2:0] FC_USER_DATA = 3'h1;
	localparam logic [2:0] FC_SUPER_DATA = 3'h5;
	localparam logic [2:0] FC_IACK = 3'h7;
	localparam logic [7:0] AUTOVEC_BASE = 8'h18;   // Level 1..7 gives 25..31.
	// ---------------------------------------------------------------
	// Bus state machine
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_S0 = 4'h1,
		ST_S1 = 4'h2,
		ST_S2 = 4'h3,
		ST_S3 = 4'h4,
		ST_S4 = 4'h5,
		ST_WAIT = 4'h6,
		ST_SYNC = 4'h7,
		ST_S5 = 4'h8,
		ST_S6 = 4'h9,
		ST_S7 = 4'ha
	} spb_state_t;
endpackage

// [rtl/spb_if.sv]
// Purpose: Pin bundle between the processor end and the peripheral end.
// Assumes: Shared buses are resolved here from drive values and enables.
// Notes: Enables are active low; an undriven bus reads as all ones.
interface spb_if;
	import spb_pkg::*;
	// ---------------------------------------------------------------
	// Pins
	// ---------------------------------------------------------------
	logic [ADDR_W-1:0] addr;            // Address drive value.
	logic addr_oe_n;                    // Address bus enable, low drives.
	logic [2:0] fc;                     // Function code.
	logic addr_valid_strobe_n;          // Address strobe.
	logic upper_byte_strobe_n;          // Upper byte data strobe.
	logic lower_byte_strobe_n;          // Lower byte data strobe.
	logic rw;                           // High read, low write.
	logic [DATA_W-1:0] dev_data;        // Processor data drive value.
	logic dev_data_oe_n;                // Processor data enable.
	logic [DATA_W-1:0] per_data;        // Peripheral data drive value.
	logic per_data_oe_n;                // Peripheral data enable.
	logic periph_enable;                // Enable clock from the processor.
	logic valid_periph_select_n;        // Valid peripheral select.
	logic sync_periph_request_n;        // Synchronous peripheral request.
	logic async_transfer_ack_n;         // Asynchronous acknowledge.
	logic [ADDR_W-1:0] addr_bus;        // Resolved address bus.
	logic [DATA_W-1:0] data_bus;        // Resolved data bus.

	// Released buses float high, as with pull-ups.
	assign addr_bus = addr_oe_n ? '1 : addr;
	assign data_bus = !dev_data_oe_n ? dev_data : (!per_data_oe_n ? per_data : '1);

	modport cpu (output addr, addr_oe_n, fc, addr_valid_strobe_n, upper_byte_strobe_n,
		lower_byte_strobe_n, rw, dev_data, dev_data_oe_n, periph_enable,
		valid_periph_select_n, input sync_periph_request_n, async_transfer_ack_n,
		data_bus);
	modport periph (input addr_bus, fc, addr_valid_strobe_n, upper_byte_strobe_n,
		lower_byte_strobe_n, rw, data_bus, periph_enable, valid_periph_select_n,
		output per_data, per_data_oe_n, sync_periph_request_n, async_transfer_ack_n);
endinterface

// [rtl/spb_cpu_end.sv]
// Purpose: Processor end of the synchronous peripheral bus cycle.
// Assumes: Request and acknowledge come from logic on the same core clock.
// Notes: One core tick is half a system clock; bus states S0..S7 other than S5 last one tick.
//
// Overview of operation
// - Enable clock is system clock divided by ten.
// - Enable low six clocks, high four clocks.
// - Select only for valid, synchronized peripheral address.
// - S0 floats address, drives function code.
// - S1 drives address, S2 asserts address strobe.
// - Read strobes in S2; write lowers read/write.
// - Write data in S3, strobes in S4.
// - Insert wait states until request recognized.
// - After recognition wait for enable low, select.
// - Peripheral uses select, transfers while enable high.
// - Prompt request recognized at end of S4.
// - Recognition three to two clocks before rise.
// - Read data captured in S6.
// - S7 negates strobes as enable falls.
// - Half clock later release address, read high.
// - Decoder makes request, drops within one clock.
// - Never acknowledge while request is asserted.
// - Select output is active low.
// - External select generator for parts lacking it.
// - Acknowledge with request uses autovector 25..31.
// - Peripherals must not decode during autovector.
module spb_cpu_end
	import spb_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_start,                         // One-tick cycle request.
	input wire logic i_write,                         // High for a write.
	input wire logic i_iack,                          // Interrupt vector fetch.
	input wire logic [2:0] i_level,                   // Level being serviced.
	input wire logic i_super,                         // Supervisor data space.
	input wire logic [spb_pkg::ADDR_W-1:0] i_addr,
	input wire logic [1:0] i_byte_en,                 // Bit 1 upper, bit 0 lower.
	input wire logic [spb_pkg::DATA_W-1:0] i_wdata,
	output logic o_busy,
	output logic o_done,                              // One-tick completion pulse.
	output logic [spb_pkg::DATA_W-1:0] o_rdata,
	output logic [7:0] o_vector,                      // Autovector number.
	output logic o_conflict,                          // Request and ack together.
	spb_if.cpu bus
);
	import spb_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [4:0] phase;                // Enable divider phase, in core ticks.
	spb_state_t state;                // Current bus state.
	spb_state_t next_state;           // State entered at the next edge.
	logic cyc_write;                  // Latched direction.
	logic cyc_iack;                   // Latched vector fetch flag.
	logic [2:0] cyc_level;            // Latched interrupt level.
	logic [2:0] cyc_fc;               // Latched function code.
	logic [1:0] cyc_be;               // Latched byte enables.
	logic [ADDR_W-1:0] cyc_addr;      // Latched address.
	logic [DATA_W-1:0] cyc_wdata;     // Latched write data.
	logic req_seen;                   // Request is asserted now.

	// True when a state lies in an inclusive range of the sequence.
	function automatic logic in_span(input spb_state_t s, input spb_state_t lo,
		input spb_state_t hi);
		in_span = (s >= lo) && (s <= hi);
	endfunction

	assign req_seen = !bus.sync_periph_request_n;

	// ---------------------------------------------------------------
	// Enable clock divider
	// ---------------------------------------------------------------
	// The divider runs free so that enable never depends on bus traffic.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			phase <= PHASE_RESET;
		end
		else if (phase == PHASE_LAST)
		begin
			phase <= PHASE_RESET;
		end
		else
		begin
			phase <= phase + 5'h01;
		end
	end

	// Enable rises after six system clocks and falls after ten.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			bus.periph_enable <= 1'b0;
		end
		else if (phase == PHASE_RISE_M1)
		begin
			bus.periph_enable <= 1'b1;
		end
		else if (phase == PHASE_LAST)
		begin
			bus.periph_enable <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Bus state machine
	// ---------------------------------------------------------------
	// Each state is one half system clock; waits repeat WAIT, SYNC or S5.
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE: next_state = i_start ? ST_S0 : ST_IDLE;
			ST_S0: next_state = ST_S1;
			ST_S1: next_state = ST_S2;
			ST_S2: next_state = ST_S3;
			ST_S3: next_state = ST_S4;
			// The request is sampled at the close of S4 and of every wait.
			ST_S4: next_state = req_seen ? ST_SYNC : ST_WAIT;
			ST_WAIT: next_state = req_seen ? ST_SYNC : ST_WAIT;
			// Select only inside the recognition window, with enable low.
			ST_SYNC:
			begin
				if (phase >= PHASE_REC_FIRST && phase <= PHASE_REC_LAST)
				begin
					next_state = ST_S5;
				end
			end
			ST_S5: next_state = (phase == PHASE_PRE_S6) ? ST_S6 : ST_S5;
			ST_S6: next_state = ST_S7;
			ST_S7: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state <= ST_IDLE;
		end
		else
		begin
			state <= next_state;
		end
	end

	// Request parameters are held for the whole cycle.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			cyc_write <= 1'b0;
			cyc_iack <= 1'b0;
			cyc_level <= 3'h0;
			cyc_fc <= 3'h0;
			cyc_be <= 2'h0;
			cyc_addr <= '0;
			cyc_wdata <= '0;
		end
		else if (state == ST_IDLE && i_start)
		begin
			// A vector fetch is always a read.
			cyc_write <= i_write && !i_iack;
			cyc_iack <= i_iack;
			cyc_level <= i_level;
			cyc_fc <= i_iack ? FC_IACK : (i_super ? FC_SUPER_DATA : FC_USER_DATA);
			cyc_be <= i_iack ? 2'h3 : i_byte_en;
			// Vector fetch puts the level on the low address bits.
			cyc_addr <= i_iack ? {{(ADDR_W-3){1'b1}}, i_level} : i_addr;
			cyc_wdata <= i_wdata;
		end
	end

	// ---------------------------------------------------------------
	// Pin outputs, registered from the state being entered
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			bus.fc <= 3'h0;
			bus.addr <= '0;
			bus.addr_oe_n <= 1'b1;
			bus.addr_valid_strobe_n <= 1'b1;
			bus.rw <= 1'b1;
		end
		else
		begin
			bus.fc <= (next_state == ST_IDLE) ? 3'h0 : cyc_fc_next();
			bus.addr <= cyc_addr;
			bus.addr_oe_n <= !in_span(next_state, ST_S1, ST_S7);
			bus.addr_valid_strobe_n <= !in_span(next_state, ST_S2, ST_S6);
			bus.rw <= !(cyc_write && in_span(next_state, ST_S2, ST_S7));
		end
	end

	// Function code for the cycle being entered, valid from S0.
	function automatic logic [2:0] cyc_fc_next();
		cyc_fc_next = (state == ST_IDLE) ?
			(i_iack ? FC_IACK : (i_super ? FC_SUPER_DATA : FC_USER_DATA)) : cyc_fc;
	endfunction

	// Data strobes open in S2 for reads and S4 for writes; all close in S7.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			bus.upper_byte_strobe_n <= 1'b1;
			bus.lower_byte_strobe_n <= 1'b1;
			bus.dev_data <= '0;
			bus.dev_data_oe_n <= 1'b1;
		end
		else
		begin
			bus.upper_byte_strobe_n <= !(cyc_be[1] && (cyc_write ?
				in_span(next_state, ST_S4, ST_S6) :
				in_span(next_state, ST_S2, ST_S6)));
			bus.lower_byte_strobe_n <= !(cyc_be[0] && (cyc_write ?
				in_span(next_state, ST_S4, ST_S6) :
				in_span(next_state, ST_S2, ST_S6)));
			bus.dev_data <= cyc_wdata;
			bus.dev_data_oe_n <= !(cyc_write && in_span(next_state, ST_S3, ST_S7));
		end
	end

	// Select is active low, so a released bus leaves every peripheral deselected.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			bus.valid_periph_select_n <= 1'b1;
		end
		else
		begin
			bus.valid_periph_select_n <= !in_span(next_state, ST_S5, ST_S6);
		end
	end

	// ---------------------------------------------------------------
	// User side results
	// ---------------------------------------------------------------
	// Read data is caught at the close of S6, the last enable-high tick.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_rdata <= '0;
			o_vector <= 8'h00;
		end
		else if (state == ST_S6 && !cyc_write)
		begin
			o_rdata <= bus.data_bus;
			if (cyc_iack)
			begin
				// The peripheral's data is ignored; the vector is internal.
				o_vector <= AUTOVEC_BASE + {5'h00, cyc_level};
			end
		end
	end

	// Status and handshake flags toward the user.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_conflict <= 1'b0;
		end
		else
		begin
			o_busy <= (next_state != ST_IDLE);
			o_done <= (state == ST_S7);
			// Both handshakes at once leave the cycle undefined; flag it.
			o_conflict <= req_seen && !bus.async_transfer_ack_n;
		end
	end
endmodule

// [rtl/spb_periph_end.sv]
// Purpose: Peripheral end: address decoder, select logic and a small register file.
// Assumes: Enable clock is asynchronous to this logic and is synchronised here.
// Notes: LOCAL_SELECT builds select from enable for processors lacking it.
module spb_periph_end
	import spb_pkg::*;
#(
	parameter logic [spb_pkg::ADDR_W-1:0] BASE_ADDR = 23'h7f_0000,
	parameter int IDX_W = 2,          // Register index bits.
	parameter bit LOCAL_SELECT = 1'b0
)
(
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_autovector_en,                 // Answer vector fetches.
	input wire logic i_load,                          // Preload a register.
	input wire logic [IDX_W-1:0] i_load_index,
	input wire logic [spb_pkg::DATA_W-1:0] i_load_data,
	output logic o_write_pulse,                       // One-tick write report.
	output logic [IDX_W-1:0] o_write_index,
	output logic [spb_pkg::DATA_W-1:0] o_write_data,
	spb_if.periph bus
);
	import spb_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] regs [2**IDX_W];   // Peripheral registers.
	logic en_meta;                        // First enable sync stage.
	logic en_sync;                        // Second enable sync stage.
	logic en_prev;                        // Enable one tick earlier.
	logic sel_ff1;                        // Local select, first stage.
	logic sel_ff2;                        // Local select, second stage.
	logic periph_hit;                     // Address inside our window.
	logic iack_hit;                       // Vector fetch we answer.
	logic chip_sel;                       // Peripheral selected now.
	logic wr_pending;                     // Write data held for commit.
	logic [DATA_W-1:0] wr_hold;           // Latched write data.
	logic [1:0] wr_be;                    // Latched byte strobes.
	logic [IDX_W-1:0] idx;                // Register index from address.

	assign idx = bus.addr_bus[IDX_W-1:0];
	assign periph_hit = (bus.fc != FC_IACK) &&
		(bus.addr_bus[ADDR_W-1:IDX_W] == BASE_ADDR[ADDR_W-1:IDX_W]);
	assign iack_hit = (bus.fc == FC_IACK) && i_autovector_en;
	// The chip never decodes a vector fetch, although select is asserted.
	assign chip_sel = (LOCAL_SELECT ? sel_ff2 : !bus.valid_periph_select_n) &&
		periph_hit && en_sync;

	// ---------------------------------------------------------------
	// Enable synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			en_meta <= 1'b0;
			en_sync <= 1'b0;
			en_prev <= 1'b0;
		end
		else
		begin
			en_meta <= bus.periph_enable;
			en_sync <= en_meta;
			en_prev <= en_sync;
		end
	end

	// ---------------------------------------------------------------
	// Decoder: request follows the strobe and drops one tick after it.
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			bus.sync_periph_request_n <= 1'b1;
			bus.async_transfer_ack_n <= 1'b1;
		end
		else
		begin
			bus.sync_periph_request_n <= !(!bus.addr_valid_strobe_n &&
				(periph_hit || iack_hit));
			// This end only answers synchronously; ack stays high.
			bus.async_transfer_ack_n <= 1'b1;
		end
	end

	// Two-stage select for processors without their own select output.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			sel_ff1 <= 1'b0;
			sel_ff2 <= 1'b0;
		end
		else if (bus.sync_periph_request_n)
		begin
			// Clears the tick after the decode is negated.
			sel_ff1 <= 1'b0;
			sel_ff2 <= 1'b0;
		end
		else
		begin
			if (en_prev && !en_sync)
			begin
				sel_ff1 <= 1'b1;
			end
			sel_ff2 <= sel_ff2 || sel_ff1;
		end
	end

	// ---------------------------------------------------------------
	// Transfer during enable high
	// ---------------------------------------------------------------
	// Read data is driven while selected and high; released with enable.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			bus.per_data <= '0;
			bus.per_data_oe_n <= 1'b1;
		end
		else
		begin
			bus.per_data <= regs[idx];
			bus.per_data_oe_n <= !(chip_sel && bus.rw);
		end
	end

	// Write data is latched while high and committed when enable falls,
	// because the processor may already have released the bus by then.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			wr_pending <= 1'b0;
			wr_hold <= '0;
			wr_be <= 2'h0;
			o_write_index <= '0;
		end
		else if (chip_sel && !bus.rw)
		begin
			wr_pending <= 1'b1;
			wr_hold <= bus.data_bus;
			wr_be <= {!bus.upper_byte_strobe_n, !bus.lower_byte_strobe_n};
			o_write_index <= idx;
		end
		else if (en_prev && !en_sync)
		begin
			wr_pending <= 1'b0;
		end
	end

	// Register file update, from the bus or from the user preload.
	always_ff @(posedge i_core_clk)
	begin
		if (wr_pending && en_prev && !en_sync)
		begin
			if (wr_be[1])
			begin
				regs[o_write_index][15:8] <= wr_hold[15:8];
			end
			if (wr_be[0])
			begin
				regs[o_write_index][7:0] <= wr_hold[7:0];
			end
		end
		else if (i_load)
		begin
			regs[i_load_index] <= i_load_data;
		end
	end

	// Write report toward the user, one tick at commit.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_write_pulse <= 1'b0;
			o_write_data <= '0;
		end
		else
		begin
			o_write_pulse <= wr_pending && en_prev && !en_sync;
			o_write_data <= wr_hold;
		end
	end
endmodule

// [tb/spb_props.sv]
// Purpose: Timing checks on the link that joins both ends.
// Assumes: One core tick is half a system clock.
// Notes: Enable is high for 8 ticks and low for 12.
module spb_props
(
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic addr_oe_n,
	input wire logic [2:0] fc,
	input wire logic addr_valid_strobe_n,
	input wire logic upper_byte_strobe_n,
	input wire logic lower_byte_strobe_n,
	input wire logic rw,
	input wire logic dev_data_oe_n,
	input wire logic periph_enable,
	input wire logic valid_periph_select_n,
	input wire logic sync_periph_request_n,
	input wire logic async_transfer_ack_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Short aliases keep the properties readable.
	wire en = periph_enable;
	wire as_n = addr_valid_strobe_n;
	wire sel_n = valid_periph_select_n;
	wire ub_n = upper_byte_strobe_n;
	wire lb_n = lower_byte_strobe_n;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_reset_n);
	// --------------------------------------------------------
	// Sequences
	// --------------------------------------------------------
	// Twelve low ticks, split since one repeat stays small.
	sequence s_en_low;
		!en [*8] ##1 !en [*4];
	endsequence
	// Write: strobe with read/write low, then data, then bytes.
	sequence s_wr;
		$fell(as_n) && ub_n && lb_n ##1 !dev_data_oe_n && ub_n && lb_n ##1 !(ub_n && lb_n);
	endsequence
	// --------------------------------------------------------
	// Properties
	// --------------------------------------------------------
	property p_en_high; $rose(en) |-> en [*8] ##1 !en; endproperty
	a_en_high: assert property (p_en_high) else $error("enable high time wrong");
	property p_en_low; $fell(en) |-> s_en_low ##1 en; endproperty
	a_en_low: assert property (p_en_low) else $error("enable low time wrong");
	property p_sel_valid; !sel_n |-> !as_n && !addr_oe_n; endproperty
	a_sel_valid: assert property (p_sel_valid) else $error("select without address");
	property p_sel_sync; $fell(sel_n) |-> !en [*3] ##[1:3] $rose(en); endproperty
	a_sel_sync: assert property (p_sel_sync) else $error("select out of step");
	property p_sel_end; $rose(sel_n) |-> $fell(en) && as_n && ub_n && lb_n; endproperty
	a_sel_end: assert property (p_sel_end) else $error("end of cycle wrong");
	property p_release; $rose(as_n) |-> !addr_oe_n ##1 (addr_oe_n && rw); endproperty
	a_release: assert property (p_release) else $error("bus release wrong");
	property p_start; $fell(addr_oe_n) |-> as_n && fc == $past(fc) && fc != 3'h0 ##1 !as_n;
	endproperty
	a_start: assert property (p_start) else $error("cycle opening wrong");
	property p_write; $fell(rw) |-> s_wr; endproperty
	a_write: assert property (p_write) else $error("write order wrong");
	property p_read; $fell(as_n) && rw |-> !(ub_n && lb_n); endproperty
	a_read: assert property (p_read) else $error("read strobe late");
	property p_req_drop; $rose(as_n) |-> ##[0:2] sync_periph_request_n; endproperty
	a_req_drop: assert property (p_req_drop) else $error("request held too long");
	property p_no_ack; async_transfer_ack_n || sync_periph_request_n; endproperty
	a_no_ack: assert property (p_no_ack) else $error("ack with request");
endmodule

// [tb/tb.sv]
// Purpose: Drives both ends of the link and checks transfers.
// Assumes: Four peripheral registers at the base address.
// Notes: Expected values come from constants, not from outputs.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import spb_pkg::*;
	localparam logic [ADDR_W-1:0] BASE = 23'h7f_0000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic start = 1'b0, wr = 1'b0, iack = 1'b0, sup = 1'b0, ave = 1'b0, load = 1'b0;
	logic [2:0] lvl = 3'h0;
	logic [1:0] be = 2'h3, li = 2'h0, widx;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wd = '0, ld = '0, rdata, wdat;
	logic [7:0] vec;
	logic done, conf, wpulse, busy;
	logic [2:0] lfc;
	int n_fail = 0, num_checks = 0, nw = 0, i, n;
	time t0, t1;
	spb_if bus();
	spb_cpu_end u_spb_cpu_end (.i_core_clk(clk), .i_reset_n(rst_n), .i_start(start),
		.i_write(wr), .i_iack(iack), .i_level(lvl), .i_super(sup), .i_addr(addr),
		.i_byte_en(be), .i_wdata(wd), .o_busy(busy), .o_done(done), .o_rdata(rdata),
		.o_vector(vec), .o_conflict(conf), .bus(bus));
	spb_periph_end #(.BASE_ADDR(BASE)) u_spb_periph_end (.i_core_clk(clk),
		.i_reset_n(rst_n), .i_autovector_en(ave), .i_load(load), .i_load_index(li),
		.i_load_data(ld), .o_write_pulse(wpulse), .o_write_index(widx),
		.o_write_data(wdat), .bus(bus));
	spb_props u_spb_props (.i_core_clk(clk), .i_reset_n(rst_n), .addr_oe_n(bus.addr_oe_n),
		.fc(bus.fc), .addr_valid_strobe_n(bus.addr_valid_strobe_n),
		.upper_byte_strobe_n(bus.upper_byte_strobe_n),
		.lower_byte_strobe_n(bus.lower_byte_strobe_n), .rw(bus.rw),
		.dev_data_oe_n(bus.dev_data_oe_n), .periph_enable(bus.periph_enable),
		.valid_periph_select_n(bus.valid_periph_select_n),
		.sync_periph_request_n(bus.sync_periph_request_n),
		.async_transfer_ack_n(bus.async_transfer_ack_n));
	// Core clock, 50 MHz.
	always #10 clk = ~clk;
	// Counts committed peripheral writes.
	always @(posedge clk)
	begin
		if (wpulse === 1'b1)
			nw <= nw + 1;
	end
	// Function code is stable from S0, so take it as the strobe falls.
	always @(negedge bus.addr_valid_strobe_n) lfc = bus.fc;
	// Compares one value and counts the outcome.
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Runs one bus cycle; a start is taken only while idle.
	task automatic cyc(input logic w, input logic ia, input logic [2:0] l,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int k;
		k = 0;
		@(posedge clk);
		start <= 1'b1;
		wr <= w;
		iack <= ia;
		lvl <= l;
		addr <= a;
		wd <= d;
		@(posedge clk);
		start <= 1'b0;
		do
		begin
			@(posedge clk);
			k++;
			// The first tick after the start is taken must show the cycle running.
			if (k == 1)
				chk("busy", 16'h1, 16'(busy));
		end
		while (done !== 1'b1 && k < 100);
		chk("done", 16'h1, 16'(done));
		chk("idle", 16'h0, 16'(busy));
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Tests take under 20 us; five times that means a hang.
	initial
	begin
		#100000;
		n_fail++;
		report_and_stop();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		chk("select idle", 16'h1, 16'(bus.valid_periph_select_n));
		rst_n <= 1'b1;
		t1 = $time;
		@(posedge bus.periph_enable);
		t0 = $time;
		// The divider restarts from phase zero, so the first rise has a fixed delay.
		chk("enable phase", 16'(EN_RISE_PHASE), 16'((t0 - t1) / 20));
		@(negedge bus.periph_enable);
		t1 = $time;
		@(posedge bus.periph_enable);
		chk("enable high", 16'((EN_DIVIDE - EN_LOW_SYS) * 2), 16'((t1 - t0) / 20));
		chk("enable period", 16'(EN_DIVIDE * 2), 16'(($time - t0) / 20));
		// Preload every register, then read them back to back.
		for (i = 0; i < 4; i++)
		begin
			@(posedge clk);
			load <= 1'b1;
			li <= 2'(i);
			ld <= 16'ha5c0 + 16'(i);
		end
		@(posedge clk);
		load <= 1'b0;
		for (i = 0; i < 4; i++)
		begin
			cyc(1'b0, 1'b0, 3'h0, BASE + 23'(i), 16'h0);
			chk("read data", 16'ha5c0 + 16'(i), rdata);
			chk("fc user", 16'(FC_USER_DATA), 16'(lfc));
		end
		// Supervisor write, then read it back.
		sup <= 1'b1;
		cyc(1'b1, 1'b0, 3'h0, BASE + 23'h2, 16'h5a3c);
		for (n = 0; n < 40 && nw == 0; n++) @(posedge clk);
		chk("write count", 16'h1, 16'(nw));
		chk("write index", 16'h2, 16'(widx));
		chk("write data", 16'h5a3c, wdat);
		cyc(1'b0, 1'b0, 3'h0, BASE + 23'h2, 16'h0);
		chk("read back", 16'h5a3c, rdata);
		chk("fc super", 16'(FC_SUPER_DATA), 16'(lfc));
		// Vector fetch for levels 1 to 7 gives its autovector.
		ave <= 1'b1;
		for (i = 1; i < 8; i++)
		begin
			cyc(1'b0, 1'b1, 3'(i), BASE, 16'h0);
			chk("autovector", 16'(AUTOVEC_BASE + 8'(i)), 16'(vec));
			chk("fc iack", 16'(FC_IACK), 16'(lfc));
		end
		chk("conflict", 16'h0, 16'(conf));
		report_and_stop();
	end
endmodule
